/* File: hw/tct_consts.vh */
// Overview of operation
// - a format-one control word picks counter, mode and byte count; counts accepted anytime
// - mode 0 starts on count load, counts with gate high, wraps past zero
// - mode 0 output low at start, high at zero, until new count or mode
// - modes 0 and 4 take a count written mid-run on the next timer tick
// - mode 1 gate rise reloads, starts and drops output; output high at zero, wraps
// - mode 1 count written while running waits for the next gate rise
// - mode 2 starts on load, reloads at one and on gate rise, gate enables
// - mode 2 output idles high, low for one tick while count equals one
// - modes 2 and 3 adopt a new count at one, mode 5 at zero; all three at gate rise
// - mode 3 output high, low after half the count; low gate forces high
// - mode 4 starts on load, gate enables, output low one tick at zero, wraps
// - mode 5 gate rise reloads, gate enables, output low one tick at zero, wraps
// - direct read shows live count; latch command freezes a snapshot for reading
// - read-back latches counts of all selected counters together
// - read-back with bit 4 clear gives status; bits 0-5 echo programming
// - status bit 6 shows count not yet loaded, bit 7 the output level
// - counters tick at about 1.19 MHz divided from the core clock, decrementing
// - gates of counters 0 and 1 tied high; counter 2 gate from input
// - control word: bit 0 bcd, bits 1-3 mode, 4-5 access, 6-7 counter
// - bits 7-6 equal 11 mean read-back: selects, status and count latch flags
`ifndef TCT_CONSTS_VH
`define TCT_CONSTS_VH

`define TCT_ADDR_CTRL 2'h3

`define TCT_CW_BCD 0
`define TCT_CW_MODE_LO 1
`define TCT_CW_RW_LO 4
`define TCT_CW_SEL_LO 6
`define TCT_CW_RB_STATUS_N 4
`define TCT_CW_RB_COUNT_N 5
`define TCT_SEL_READBACK 2'h3

`define TCT_RW_LATCH 2'h0
`define TCT_RW_LSB 2'h1
`define TCT_RW_MSB 2'h2
`define TCT_RW_BOTH 2'h3

`define TCT_MODE_0 3'h0
`define TCT_MODE_1 3'h1
`define TCT_MODE_2 3'h2
`define TCT_MODE_3 3'h3
`define TCT_MODE_4 3'h4
`define TCT_MODE_5 3'h5

`define TCT_REF_CLK_HZ 100000000
`define TCT_TIMER_CLK_HZ 1190000
`define TCT_TICK_DIV (`TCT_REF_CLK_HZ / `TCT_TIMER_CLK_HZ)

`endif

/* File: hw/tct_timer.v */
`timescale 1ns/10ps
`include "tct_consts.vh"

module tct_timer #(
  parameter TICK_DIV = `TCT_TICK_DIV
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [1:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  input wire speaker_counter_gate,
  output wire [2:0] timer_out
);

  // bcd-aware decrement; zero wraps to the top of the range
  function [15:0] tct_dec;
    input [15:0] v;
    input b;
    reg [3:0] nib;
    reg borrow;
    integer i;
    begin
      tct_dec = v - 16'h0001;
      if (b) begin
        borrow = 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
          nib = v[4*i +: 4];
          if (borrow) begin
            if (nib == 4'h0) begin
              nib = 4'h9;
            end else begin
              nib = nib - 4'h1;
              borrow = 1'b0;
            end
          end
          tct_dec[4*i +: 4] = nib;
        end
      end
    end
  endfunction

  // timer tick divider
  reg [15:0] div_cnt;
  reg tick;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (div_cnt == TICK_DIV[15:0] - 16'h0001) begin
      div_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  wire ctrl_wr = io_wr && (io_addr == `TCT_ADDR_CTRL);
  wire is_rb = io_wdata[7:6] == `TCT_SEL_READBACK;
  wire [2:0] gate_in = {speaker_counter_gate, 2'b11};
  wire [7:0] rd_byte [0:2];

  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : ch
      reg [2:0] mode;
      reg bcd;
      reg [1:0] rw;
      reg [15:0] cr;
      reg [15:0] cnt;
      reg [15:0] ol;
      reg ol_valid;
      reg [7:0] st;
      reg st_valid;
      reg null_cnt;
      reg load_req;
      reg have_cnt;
      reg running;
      reg out;
      reg gate_prev;
      reg wr_msb;
      reg rd_msb;

      wire sel_cw = ctrl_wr && !is_rb && (io_wdata[7:6] == c);
      wire sel_rb = ctrl_wr && is_rb && io_wdata[c+1];
      wire cnt_wr = io_wr && (io_addr == c);
      wire cnt_rd = io_rd && (io_addr == c);
      wire gate = gate_in[c];
      wire gate_rise = gate && !gate_prev;
      wire [15:0] dec = tct_dec(cnt, bcd);
      wire [15:0] src = ol_valid ? ol : cnt;
      // codes x10 and x11 fold onto modes 2 and 3; the others are taken as written
      wire [2:0] cw_mode = io_wdata[2] ? {1'b0, io_wdata[2:1]} : io_wdata[3:1];
      // a count is complete once the access function has got all its bytes
      wire cnt_done = cnt_wr && ((rw != `TCT_RW_BOTH) || wr_msb);

      assign rd_byte[c] = st_valid ? st :
                          (rw == `TCT_RW_MSB) ? src[15:8] :
                          ((rw == `TCT_RW_BOTH) && rd_msb) ? src[15:8] : src[7:0];
      assign timer_out[c] = out;

      always @(posedge ref_clk) begin
        if (sys_rst) begin
          mode <= `TCT_MODE_0;
          bcd <= 1'b0;
          rw <= `TCT_RW_LSB;
          cr <= 16'h0000;
          cnt <= 16'h0000;
          ol <= 16'h0000;
          ol_valid <= 1'b0;
          st <= 8'h00;
          st_valid <= 1'b0;
          null_cnt <= 1'b0;
          load_req <= 1'b0;
          have_cnt <= 1'b0;
          running <= 1'b0;
          out <= 1'b1;
          gate_prev <= 1'b0;
          wr_msb <= 1'b0;
          rd_msb <= 1'b0;
        end else begin
          // counting element, advanced once per timer tick
          if (tick) begin
            gate_prev <= gate;
            case (mode)
              `TCT_MODE_0, `TCT_MODE_4: begin
                if (load_req) begin
                  cnt <= cr;
                  null_cnt <= 1'b0;
                  load_req <= 1'b0;
                  running <= 1'b1;
                  out <= (mode == `TCT_MODE_4);
                end else if (running && gate) begin
                  cnt <= dec;
                  if (mode == `TCT_MODE_0) begin
                    if (dec == 16'h0000) begin
                      out <= 1'b1;
                    end
                  end else begin
                    out <= (dec != 16'h0000);
                  end
                end else if (mode == `TCT_MODE_4) begin
                  out <= 1'b1;
                end
              end
              `TCT_MODE_1: begin
                if (gate_rise && have_cnt) begin
                  cnt <= cr;
                  null_cnt <= 1'b0;
                  load_req <= 1'b0;
                  running <= 1'b1;
                  out <= 1'b0;
                end else if (running) begin
                  cnt <= dec;
                  if (dec == 16'h0000) begin
                    out <= 1'b1;
                  end
                end
              end
              `TCT_MODE_2, `TCT_MODE_3: begin
                if ((load_req && !running) || (gate_rise && have_cnt)) begin
                  cnt <= cr;
                  null_cnt <= 1'b0;
                  load_req <= 1'b0;
                  running <= 1'b1;
                  out <= 1'b1;
                end else if (running && gate) begin
                  if (cnt == 16'h0001) begin
                    cnt <= cr;
                    null_cnt <= 1'b0;
                    load_req <= 1'b0;
                  end else begin
                    cnt <= dec;
                  end
                  if (mode == `TCT_MODE_2) begin
                    out <= (dec != 16'h0001);
                  end else begin
                    // low once half of the reload value has elapsed
                    out <= (cnt == 16'h0001) || (dec > {1'b0, cr[15:1]});
                  end
                end else if (!gate) begin
                  out <= 1'b1;
                end
              end
              `TCT_MODE_5: begin
                if ((gate_rise && have_cnt) || (running && gate && load_req &&
                    (cnt == 16'h0000))) begin
                  cnt <= cr;
                  null_cnt <= 1'b0;
                  load_req <= 1'b0;
                  running <= 1'b1;
                  out <= 1'b1;
                end else if (running && gate) begin
                  cnt <= dec;
                  out <= (dec != 16'h0000);
                end else begin
                  out <= 1'b1;
                end
              end
              default: begin
                running <= 1'b0;
              end
            endcase
          end

          // host reads: status first, then the snapshot or the live count
          if (cnt_rd) begin
            if (st_valid) begin
              st_valid <= 1'b0;
            end else begin
              if (rw == `TCT_RW_BOTH) begin
                rd_msb <= !rd_msb;
              end
              if (ol_valid && ((rw != `TCT_RW_BOTH) || rd_msb)) begin
                ol_valid <= 1'b0;
              end
            end
          end

          // count writes come after the tick so a new load request is never lost
          if (cnt_wr) begin
            case (rw)
              `TCT_RW_LSB: cr <= {8'h00, io_wdata};
              `TCT_RW_MSB: cr <= {io_wdata, 8'h00};
              default: begin
                if (wr_msb) begin
                  cr[15:8] <= io_wdata;
                end else begin
                  cr[7:0] <= io_wdata;
                end
                wr_msb <= !wr_msb;
              end
            endcase
          end
          if (cnt_done) begin
            null_cnt <= 1'b1;
            have_cnt <= 1'b1;
            // mode 1 ignores this; it loads only on a gate rise
            load_req <= 1'b1;
            if (mode == `TCT_MODE_0) begin
              out <= 1'b0;
            end
          end

          // control words
          if (sel_cw) begin
            if (io_wdata[5:4] == `TCT_RW_LATCH) begin
              if (!ol_valid) begin
                ol <= cnt;
                ol_valid <= 1'b1;
              end
            end else begin
              mode <= cw_mode;
              bcd <= io_wdata[`TCT_CW_BCD];
              rw <= io_wdata[5:4];
              wr_msb <= 1'b0;
              rd_msb <= 1'b0;
              ol_valid <= 1'b0;
              st_valid <= 1'b0;
              null_cnt <= 1'b1;
              have_cnt <= 1'b0;
              load_req <= 1'b0;
              running <= 1'b0;
              out <= (cw_mode != `TCT_MODE_0);
            end
          end
          if (sel_rb) begin
            if (!io_wdata[`TCT_CW_RB_COUNT_N] && !ol_valid) begin
              ol <= cnt;
              ol_valid <= 1'b1;
            end
            if (!io_wdata[`TCT_CW_RB_STATUS_N] && !st_valid) begin
              st <= {out, null_cnt, rw, mode, bcd};
              st_valid <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      case (io_addr)
        2'h0: io_rdata <= rd_byte[0];
        2'h1: io_rdata <= rd_byte[1];
        2'h2: io_rdata <= rd_byte[2];
        default: io_rdata <= 8'h00;
      endcase
    end
  end

endmodule

/* File: test/tct_timer_asserts.sv */
`timescale 1ns/10ps
module tct_timer_asserts #(
  parameter TICK_DIV = 4
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [1:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire speaker_counter_gate,
  input wire [2:0] timer_out
);
  wire cw_wr;
  reg [5:0] cw1;
  reg [2:0] md2;
  reg [15:0] low1;
  assign cw_wr = io_wr && io_addr == 2'h3 && io_wdata[7:6] != 2'h3 && io_wdata[5:4] != 2'h0;
  always @(posedge ref_clk) begin
    low1 <= timer_out[1] ? 16'h0000 : low1 + 16'h0001;
    if (sys_rst) begin
      cw1 <= 6'h10;
      md2 <= 3'h0;
    end else if (cw_wr && io_wdata[7:6] == 2'h1) begin
      cw1 <= io_wdata[5:0];
    end else if (cw_wr && io_wdata[7:6] == 2'h2) begin
      md2 <= io_wdata[3:1];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_ctrl_rd;
    io_rd && io_addr == 2'h3 |=> io_rdata == 8'h00;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read not zero");
  property p_hold;
    !io_rd |=> $stable(io_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_m2_pulse;
    cw1[3:1] == 3'h2 && $stable(cw1) && $rose(timer_out[1]) |-> low1 == TICK_DIV;
  endproperty
  a_m2_pulse: assert property (p_m2_pulse) else $error("rate pulse width");
  property p_m4_pulse;
    cw1[3:1] == 3'h4 && $stable(cw1) && $rose(timer_out[1]) |-> low1 == TICK_DIV;
  endproperty
  a_m4_pulse: assert property (p_m4_pulse) else $error("strobe width");
  property p_echo;
    $past(io_wr && io_addr == 2'h3 && io_wdata == 8'hE4, 2) && io_rd && io_addr == 2'h1
      |=> io_rdata[5:0] == cw1 && io_rdata[7] == $past(timer_out[1], 3);
  endproperty
  a_echo: assert property (p_echo) else $error("status byte wrong");
  property p_m0_low;
    cw_wr && io_wdata[7:6] == 2'h2 && io_wdata[3:1] == 3'h0 |=> !timer_out[2];
  endproperty
  a_m0_low: assert property (p_m0_low) else $error("mode 0 output not low");
  property p_mode_high;
    cw_wr && io_wdata[7:6] == 2'h1 && io_wdata[3:1] != 3'h0 |=> timer_out[1];
  endproperty
  a_mode_high: assert property (p_mode_high) else $error("output not high");
  property p_m0_hold;
    md2 == 3'h0 && $rose(timer_out[2])
      |=> (timer_out[2] [*4]) or (##[0:3] (io_wr && io_addr[1]));
  endproperty
  a_m0_hold: assert property (p_m0_hold) else $error("mode 0 high lost");
  c_m2: cover property (cw1[3:1] == 3'h2 && $fell(timer_out[1]));
  c_m3: cover property (cw1[3:1] == 3'h3 && $fell(timer_out[1]));
  c_m0: cover property (md2 == 3'h0 && $rose(timer_out[2]));
endmodule
bind tct_timer tct_timer_asserts #(.TICK_DIV(TICK_DIV)) u_chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .speaker_counter_gate(speaker_counter_gate), .timer_out(timer_out));

/* File: test/tct_host.sv */
`timescale 1ns/10ps
module tct_host (
  input wire ref_clk,
  output reg [1:0] io_addr,
  output reg io_wr,
  output reg io_rd,
  output reg [7:0] io_wdata,
  input wire [7:0] io_rdata
);
  initial begin
    io_addr = 2'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // called at a rising edge; each idle cycle inverts the last data, so a stale byte shows again on every second idle cycle
  task op(input w, input r, input [1:0] a, input [7:0] d);
    begin
      #1;
      io_wr = w;
      io_rd = r;
      io_addr = a;
      io_wdata = w ? d : ~io_wdata;
      @(posedge ref_clk);
    end
  endtask
endmodule

/* File: test/tct_timer_tb.sv */
`timescale 1ns/10ps
module tct_timer_tb;
  localparam [31:0] CW = 32'h7876_0074;
  localparam [31:0] CN = 32'h0204_0503;
  localparam [31:0] LO = 32'h0408_0404;
  localparam [31:0] PR = 32'h0010_140C;
  reg ref_clk;
  reg sys_rst;
  reg speaker_counter_gate;
  wire [1:0] io_addr;
  wire io_wr, io_rd;
  wire [7:0] io_wdata, io_rdata;
  wire [2:0] timer_out;
  integer err_total, checks_done, n;
  reg [7:0] v;
  tct_timer #(.TICK_DIV(4)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .speaker_counter_gate(speaker_counter_gate), .timer_out(timer_out));
  tct_host host (.ref_clk(ref_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task end_of_test;
    begin
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [8*8:1] nm, input [7:0] e, input [7:0] s);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task wr(input [1:0] a, input [7:0] d);
    begin
      host.op(1'b1, 1'b0, a, d);
      host.op(1'b0, 1'b0, ~a, 8'h00);
    end
  endtask
  task rd(input [1:0] a, input [7:0] e, input [8*8:1] nm);
    begin
      host.op(1'b0, 1'b1, a, 8'h00);
      host.op(1'b0, 1'b0, ~a, 8'h00);
      chk(nm, e, io_rdata);
    end
  endtask
  task wt(input b);
    integer i;
    begin
      for (i = 0; i < 400 && timer_out[1] !== b; i = i + 1) begin
        @(posedge ref_clk);
        #1;
      end
    end
  endtask
  // low width and fall-to-fall period of counter 1, in ref_clk cycles
  task meas(input [7:0] lo, input [7:0] per);
    integer c;
    begin
      wt(1'b1);
      wt(1'b0);
      c = 0;
      while (timer_out[1] === 1'b0 && c < 400) begin
        @(posedge ref_clk);
        #1;
        c = c + 1;
      end
      chk("low", lo, c[7:0]);
      if (per != 8'h00) begin
        while (timer_out[1] === 1'b1 && c < 400) begin
          @(posedge ref_clk);
          #1;
          c = c + 1;
        end
        chk("period", per, c[7:0]);
      end
    end
  endtask
  initial begin
    #100000;
    err_total = err_total + 1;
    $display("[ERR] watchdog exp done got hang");
    end_of_test;
  end
  initial begin
    err_total = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    speaker_counter_gate = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    @(posedge ref_clk);
    rd(2'h3, 8'h00, "ctrl");
    wr(2'h3, 8'hB0);
    wr(2'h2, 8'h03);
    wr(2'h3, 8'hE8);
    rd(2'h2, 8'h70, "stat a");
    wr(2'h2, 8'h00);
    repeat (12) @(posedge ref_clk);
    wr(2'h3, 8'hE8);
    rd(2'h2, 8'h30, "stat b");
    chk("out2 lo", 8'h00, {7'h00, timer_out[2]});
    rd(2'h2, 8'h03, "live lo");
    rd(2'h2, 8'h00, "live hi");
    wr(2'h3, 8'h80);
    wr(2'h3, 8'h80);
    #1 speaker_counter_gate = 1'b1;
    repeat (40) @(posedge ref_clk);
    chk("out2 hi", 8'h01, {7'h00, timer_out[2]});
    rd(2'h2, 8'h03, "snap lo");
    rd(2'h2, 8'h00, "snap hi");
    wr(2'h3, 8'hD8);
    host.op(1'b0, 1'b1, 2'h2, 8'h00);
    host.op(1'b0, 1'b0, 2'h1, 8'h00);
    rd(2'h2, 8'hFF, "wrap hi");
    for (n = 0; n < 4; n = n + 1) begin
      v = CW[8*n +: 8];
      if (v != 8'h00) wr(2'h3, v);
      wr(2'h1, CN[8*n +: 8]);
      wr(2'h1, 8'h00);
      meas(LO[8*n +: 8], PR[8*n +: 8]);
      if (v != 8'h00) begin
        wr(2'h3, 8'hE4);
        host.op(1'b0, 1'b1, 2'h1, 8'h00);
        host.op(1'b0, 1'b0, 2'h2, 8'h00);
        chk("echo", {2'h0, v[5:0]}, {2'h0, io_rdata[5:0]});
        chk("loaded", 8'h00, {7'h00, io_rdata[6]});
      end
    end
    end_of_test;
  end
endmodule
